// File: core/pmlsp_fifo.sv
`timescale 1ns/1ps
module pmlsp_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RST,
  pmlsp_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign f.in_ready  = (count != (AW+1)'(DEPTH));
  assign f.out_valid = (count != '0);
  assign do_wr       = f.in_valid && f.in_ready;
  assign do_rd       = f.out_valid && f.out_ready;

  // read data is taken combinationally from the memory entry at the read pointer
  always_ff @(posedge CLK) begin
    if (do_wr) begin
      mem[wr_ptr] <= f.in_data;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  assign f.out_data = mem[rd_ptr];

endmodule : pmlsp_fifo

// File: core/pmlsp_fifo_if.sv
`timescale 1ns/1ps
interface pmlsp_fifo_if #(parameter int WIDTH = 4);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport fill  (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
  modport store (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface : pmlsp_fifo_if

// File: core/pmlsp_pkg.sv
package pmlsp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] PMLSP_BASIC_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] PMLSP_STRAP_STAT_ADDR  = 8'h04;
  localparam logic [7:0] PMLSP_LINK_CTRL_ADDR   = 8'h08;
  localparam logic [7:0] PMLSP_TX_DATA_ADDR     = 8'h0c;
  localparam logic [7:0] PMLSP_FIFO_STAT_ADDR   = 8'h10;
  localparam logic [7:0] PMLSP_VENDOR_CTRL_ADDR = 8'h7c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PMLSP_SPEED_BIT     = 13;
  localparam int PMLSP_ANEG_BIT      = 12;
  localparam int PMLSP_LED_MODE_LSB  = 4;
  localparam int PMLSP_CFG_WIDTH     = 3;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  PMLSP_LED_MODE_RST = 2'h0;
  localparam logic [2:0]  PMLSP_CFG_MII      = 3'h0;
  localparam logic [2:0]  PMLSP_CFG_B2B      = 3'h6;
  localparam logic [31:0] PMLSP_SLVERR_DATA  = 32'h0;

  // ----------------------------------------------------------------
  // timing: blink half period, in ns and in cycles of a 25 ns clock
  // ----------------------------------------------------------------
  localparam int PMLSP_CLK_NS        = 25;
  localparam int PMLSP_BLINK_HALF_NS = 100000;
  localparam int PMLSP_BLINK_CYCLES  = PMLSP_BLINK_HALF_NS / PMLSP_CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMLSP_LED_LINK_ACT = 2'b00,
    PMLSP_LED_BLINK    = 2'b01,
    PMLSP_LED_RSV2     = 2'b10,
    PMLSP_LED_RSV3     = 2'b11
  } pmlsp_led_mode_t;

  typedef enum logic [1:0] {
    PMLSP_ST_RESET  = 2'b00,
    PMLSP_ST_LATCH  = 2'b01,
    PMLSP_ST_NORMAL = 2'b10
  } pmlsp_state_t;

endpackage : pmlsp_pkg

// File: core/pmlsp_top.sv
`timescale 1ns/1ps
// Function
// - collision pin drives normally; its reset level becomes strap bit zero
// - carrier sense pin drives normally; its reset level becomes strap bit one
// - first led pin level at reset release sets auto-negotiation enable
// - second led pin level at reset release goes to basic control bit 13
// - straps sampled exactly at reset release, then pins become outputs
// - strap code 000 is normal mii, 110 back-to-back, others reserved; strap bit two is tied to zero, so 110 is never captured
module pmlsp_top
  import pmlsp_pkg::*;
#(
  parameter int BLINK_CYCLES = PMLSP_BLINK_CYCLES,
  parameter int FIFO_DEPTH   = 8
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // chip reset pin, active low
  input  wire logic        CHIP_RST_N,
  // mii transmit from the mac
  input  wire logic [3:0]  TXD,
  input  wire logic        TXEN,
  // line side: nibbles leave through the fifo
  output logic      [3:0]  LINE_DATA,
  output logic             LINE_VALID,
  input  wire logic        LINE_READY,
  // line status from the analog side
  input  wire logic        LINK_UP,
  input  wire logic        LINE_COLLISION,
  input  wire logic        LINE_CARRIER,
  // dual purpose pins
  input  wire logic        COL_IN,
  output logic             COL_OUT,
  output logic             COL_OE,
  input  wire logic        CRS_IN,
  output logic             CRS_OUT,
  output logic             CRS_OE,
  input  wire logic        LINK_ACTIVITY_LED_IN,
  output logic             LINK_ACTIVITY_LED_OUT,
  output logic             LINK_ACTIVITY_LED_OE,
  input  wire logic        SECOND_STATUS_LED_IN,
  output logic             SECOND_STATUS_LED_OUT,
  output logic             SECOND_STATUS_LED_OE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // the mii, chip reset and dual purpose pins are outside the clock domain: two flops before any use
  logic [9:0] sync_a;
  logic [9:0] sync_b;
  logic [3:0] txd_s;
  logic       txen_s;
  logic       rst_n_s;
  logic       col_s;
  logic       crs_s;
  logic       link_activity_led_s;
  logic       second_status_led_s;

  always_ff @(posedge CLK) begin
    if (RST) begin
      sync_a <= 10'h000;
      sync_b <= 10'h000;
    end else begin
      sync_a <= {SECOND_STATUS_LED_IN, LINK_ACTIVITY_LED_IN, CRS_IN, COL_IN,
                 CHIP_RST_N, TXEN, TXD};
      sync_b <= sync_a;
    end
  end

  assign txd_s   = sync_b[3:0];
  assign txen_s  = sync_b[4];
  assign rst_n_s = sync_b[5];
  assign col_s   = sync_b[6];
  assign crs_s   = sync_b[7];
  assign link_activity_led_s  = sync_b[8];
  assign second_status_led_s  = sync_b[9];

  // ----------------------------------------------------------------
  // chip reset sequencing and strap capture
  // ----------------------------------------------------------------
  pmlsp_state_t state;
  pmlsp_state_t next_state;
  logic [2:0]   cfg_strap;
  logic         autoneg_enable_strap;
  logic         speed_strap;
  logic         pins_drive;
  logic         cfg_reserved;

  always_comb begin
    next_state = state;
    unique case (state)
      PMLSP_ST_RESET:  if (rst_n_s) next_state = PMLSP_ST_LATCH;
      PMLSP_ST_LATCH:  next_state = PMLSP_ST_NORMAL;
      PMLSP_ST_NORMAL: if (!rst_n_s) next_state = PMLSP_ST_RESET;
      default:         next_state = PMLSP_ST_RESET;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= PMLSP_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // straps taken in the very cycle the synchronised reset goes high
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_strap            <= PMLSP_CFG_MII;
      autoneg_enable_strap <= 1'b0;
      speed_strap          <= 1'b0;
    end else if (state == PMLSP_ST_RESET && rst_n_s) begin
      cfg_strap[0]         <= col_s;
      cfg_strap[1]         <= crs_s;
      cfg_strap[2]         <= 1'b0;
      autoneg_enable_strap <= link_activity_led_s;
      speed_strap          <= second_status_led_s;
    end
  end

  // pins only drive once out of reset; while in reset the pulls set the level
  assign pins_drive   = (state != PMLSP_ST_RESET);
  assign cfg_reserved = (cfg_strap != PMLSP_CFG_MII) && (cfg_strap != PMLSP_CFG_B2B);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]     basic_ctrl;
  logic [1:0]      led_mode;
  logic            apb_wr;
  logic            apb_rd;
  logic            addr_ok;
  logic            tx_push;
  pmlsp_led_mode_t mode;

  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign mode   = pmlsp_led_mode_t'(led_mode);

  always_comb begin
    unique case (PADDR)
      PMLSP_BASIC_CTRL_ADDR, PMLSP_STRAP_STAT_ADDR, PMLSP_LINK_CTRL_ADDR,
      PMLSP_TX_DATA_ADDR, PMLSP_FIFO_STAT_ADDR, PMLSP_VENDOR_CTRL_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      basic_ctrl <= 16'h0000;
    end else if (state == PMLSP_ST_LATCH) begin
      basic_ctrl[PMLSP_SPEED_BIT] <= speed_strap;
      basic_ctrl[PMLSP_ANEG_BIT]  <= autoneg_enable_strap;
    end else if (apb_wr && PADDR == PMLSP_BASIC_CTRL_ADDR) begin
      basic_ctrl <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      led_mode <= PMLSP_LED_MODE_RST;
    end else if (apb_wr && PADDR == PMLSP_VENDOR_CTRL_ADDR) begin
      led_mode <= PWDATA[PMLSP_LED_MODE_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // transmit path through the fifo
  // ----------------------------------------------------------------
  pmlsp_fifo_if #(.WIDTH(4)) tx_if ();

  pmlsp_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) u_fifo (
    .CLK (CLK),
    .RST (RST),
    .f   (tx_if)
  );

  // nibbles sampled only while enable is high; the mac sends them in step
  assign tx_push          = txen_s && (state == PMLSP_ST_NORMAL);
  assign tx_if.in_valid   = tx_push;
  assign tx_if.in_data    = txd_s;
  assign tx_if.out_ready  = LINE_READY;
  assign LINE_VALID       = tx_if.out_valid;
  assign LINE_DATA        = tx_if.out_data;

  // a full fifo drops nibbles: the mii has no back-pressure, so count them
  logic [15:0] drop_count;
  always_ff @(posedge CLK) begin
    if (RST) begin
      drop_count <= 16'h0000;
    end else if (tx_push && !tx_if.in_ready && drop_count != 16'hffff) begin
      drop_count <= drop_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  always_comb begin
    PRDATA = PMLSP_SLVERR_DATA;
    if (apb_rd) begin
      unique case (PADDR)
        PMLSP_BASIC_CTRL_ADDR:  PRDATA = {16'h0000, basic_ctrl};
        PMLSP_STRAP_STAT_ADDR:  PRDATA = {27'h0, cfg_reserved, speed_strap,
                                          autoneg_enable_strap, cfg_strap[1:0]};
        PMLSP_LINK_CTRL_ADDR:   PRDATA = {29'h0, LINE_CARRIER, LINE_COLLISION, LINK_UP};
        PMLSP_FIFO_STAT_ADDR:   PRDATA = {16'h0000, drop_count};
        PMLSP_VENDOR_CTRL_ADDR: PRDATA = {26'h0, led_mode, 4'h0};
        default:                PRDATA = PMLSP_SLVERR_DATA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // led blink divider and pin outputs
  // ----------------------------------------------------------------
  logic [$clog2(BLINK_CYCLES+1)-1:0] blink_cnt;
  logic                              blink_tick;
  logic                              blink_phase;
  logic                              activity;
  logic                              link_activity_led;
  logic                              second_status_led;

  assign blink_tick = (blink_cnt == '0);
  assign activity   = tx_push || LINE_CARRIER;

  always_ff @(posedge CLK) begin
    if (RST) begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end else begin
      blink_cnt <= blink_tick ? ($bits(blink_cnt))'(BLINK_CYCLES - 1) : blink_cnt - 1'b1;
      if (blink_tick) begin
        blink_phase <= !blink_phase;
      end
    end
  end

  // led pins: low is on; toggling is paced by the divider so it is visible
  always_ff @(posedge CLK) begin
    if (RST) begin
      link_activity_led <= 1'b1;
      second_status_led <= 1'b1;
    end else begin
      unique case (mode)
        PMLSP_LED_LINK_ACT: begin
          link_activity_led <= !LINK_UP ? 1'b1 : (activity ? blink_phase : 1'b0);
          second_status_led <= 1'b1;
        end
        PMLSP_LED_BLINK: begin
          link_activity_led <= !LINK_UP ? 1'b1 : (activity ? blink_phase : 1'b0);
          second_status_led <= activity ? blink_phase : 1'b1;
        end
        default: begin
          link_activity_led <= 1'b1;
          second_status_led <= 1'b1;
        end
      endcase
    end
  end

  // collision and carrier outputs registered, then driven after reset
  logic col_q;
  logic crs_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      col_q <= 1'b0;
      crs_q <= 1'b0;
    end else begin
      col_q <= LINE_COLLISION && pins_drive;
      crs_q <= (LINE_CARRIER || tx_push) && pins_drive;
    end
  end

  assign COL_OUT               = col_q;
  assign COL_OE                = pins_drive;
  assign CRS_OUT               = crs_q;
  assign CRS_OE                = pins_drive;
  assign LINK_ACTIVITY_LED_OUT = link_activity_led;
  assign LINK_ACTIVITY_LED_OE  = pins_drive;
  assign SECOND_STATUS_LED_OUT = second_status_led;
  assign SECOND_STATUS_LED_OE  = pins_drive;

endmodule : pmlsp_top

// File: testbench/pmlsp_chk_properties.sv
`timescale 1ns/1ps
module pmlsp_chk
  import pmlsp_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CHIP_RST_N,
  // status and line side
  input wire logic        LINK_UP,
  input wire logic        LINE_COLLISION,
  input wire logic        LINE_CARRIER,
  input wire logic        TXEN,
  input wire logic        LINE_READY,
  input wire logic        LINE_VALID,
  input wire logic [3:0]  LINE_DATA,
  // pins
  input wire logic        COL_OUT,
  input wire logic        COL_OE,
  input wire logic        CRS_OUT,
  input wire logic        CRS_OE,
  input wire logic        LINK_ACTIVITY_LED_OUT,
  input wire logic        LINK_ACTIVITY_LED_OE,
  input wire logic        SECOND_STATUS_LED_OE,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // shadow of the led mode field, seen from the bus
  // ----------------------------------------------------------------
  logic [1:0] led_mode;
  always_ff @(posedge CLK) begin
    if (RST) begin
      led_mode <= PMLSP_LED_MODE_RST;
    end else if (PSEL && PENABLE && PWRITE && PADDR == PMLSP_VENDOR_CTRL_ADDR) begin
      led_mode <= PWDATA[5:4];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_pin_rise;
    !CHIP_RST_N ##1 CHIP_RST_N [*3];
  endsequence
  property p_oe_rise;
    s_pin_rise |=> $rose(COL_OE);
  endproperty
  property p_oe_hold;
    !CHIP_RST_N [*3] |=> !COL_OE;
  endproperty
  property p_oe_same;
    COL_OE == CRS_OE && COL_OE == LINK_ACTIVITY_LED_OE && COL_OE == SECOND_STATUS_LED_OE;
  endproperty
  property p_col;
    COL_OE && $past(COL_OE) |-> COL_OUT == $past(LINE_COLLISION);
  endproperty
  // own transmit also raises carrier sense; enable reaches the pin three edges on
  property p_crs;
    CRS_OE && $past(CRS_OE) && $past(CRS_OE, 2)
      |-> CRS_OUT == ($past(LINE_CARRIER) || $past(TXEN, 3));
  endproperty
  property p_link_activity_led;
    led_mode == 2'h0 && $past(led_mode) == 2'h0 && $past(COL_OE) && !$past(LINK_UP)
      |-> LINK_ACTIVITY_LED_OUT;
  endproperty
  property p_pready;
    PSEL |-> PREADY;
  endproperty
  property p_unmapped;
    PSEL && PENABLE && !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h7c})
      |-> PSLVERR && PRDATA == PMLSP_SLVERR_DATA;
  endproperty
  property p_line_hold;
    LINE_VALID && !LINE_READY |=> LINE_VALID && $stable(LINE_DATA);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("pins not driven after release");
  a_oe_hold: assert property (p_oe_hold) else $error("pins driven in chip reset");
  a_oe_same: assert property (p_oe_same) else $error("pin enables differ");
  a_col: assert property (p_col) else $error("collision pin wrong");
  a_crs: assert property (p_crs) else $error("carrier pin wrong");
  a_link_activity_led: assert property (p_link_activity_led) else $error("first led lit without link");
  a_pready: assert property (p_pready) else $error("bus not ready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  a_line_hold: assert property (p_line_hold) else $error("line data moved");
endmodule : pmlsp_chk
bind pmlsp_top pmlsp_chk u_chk (.CLK, .RST, .CHIP_RST_N, .LINK_UP, .LINE_COLLISION,
  .LINE_CARRIER, .TXEN, .LINE_READY, .LINE_VALID, .LINE_DATA, .COL_OUT, .COL_OE, .CRS_OUT,
  .CRS_OE, .LINK_ACTIVITY_LED_OUT, .LINK_ACTIVITY_LED_OE, .SECOND_STATUS_LED_OE,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);

// File: testbench/pmlsp_mac_model.sv
`timescale 1ns/1ps
module pmlsp_mac_model (
  // clock and control
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       start,
  input  wire logic [4:0] count,
  // mii transmit
  output logic      [3:0] TXD = 4'h0,
  output logic            TXEN = 1'b0,
  output logic            busy
);
  logic [4:0] left;
  logic [3:0] nib;
  assign busy = (left != 5'h0) || TXEN;
  always @(posedge CLK) begin
    if (RST) begin
      TXEN <= 1'b0;
      left <= 5'h0;
    end else if (left != 5'h0) begin
      TXEN <= 1'b1;
      TXD  <= nib;
      nib  <= nib + 4'h1;
      left <= left - 5'h1;
    end else begin
      TXEN <= 1'b0;
      // outside frames the data lines keep changing, so no stale nibble looks valid
      TXD  <= ~TXD;
      if (start) begin
        left <= count;
        nib  <= 4'h0;
      end
    end
  end
endmodule : pmlsp_mac_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import pmlsp_pkg::*;
  logic CLK = 0, RST = 1, CHIP_RST_N = 0, LINE_READY = 1, LINK_UP = 0;
  logic LINE_COLLISION = 0, LINE_CARRIER = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [3:0] TXD, LINE_DATA, strap = 4'h0;
  logic TXEN, LINE_VALID, PREADY, PSLVERR, er, go = 0, busy;
  logic COL_OUT, COL_OE, CRS_OUT, CRS_OE, LINK_ACTIVITY_LED_OUT, LINK_ACTIVITY_LED_OE;
  logic SECOND_STATUS_LED_OUT, SECOND_STATUS_LED_OE;
  logic [4:0] cnt = 5'h0;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  // pin levels: the pull or strap value until the device drives the pin
  wire COL_IN = COL_OE ? COL_OUT : strap[0];
  wire CRS_IN = CRS_OE ? CRS_OUT : strap[1];
  wire LINK_ACTIVITY_LED_IN = LINK_ACTIVITY_LED_OE ? LINK_ACTIVITY_LED_OUT : strap[2];
  wire SECOND_STATUS_LED_IN = SECOND_STATUS_LED_OE ? SECOND_STATUS_LED_OUT : strap[3];
  always #12.5 CLK = ~CLK;
  pmlsp_mac_model u_mac (.CLK, .RST, .start(go), .count(cnt), .TXD, .TXEN, .busy);
  pmlsp_top #(.BLINK_CYCLES(4), .FIFO_DEPTH(8)) u_dut (.CLK, .RST, .CHIP_RST_N, .TXD, .TXEN,
    .LINE_DATA, .LINE_VALID, .LINE_READY, .LINK_UP, .LINE_COLLISION, .LINE_CARRIER,
    .COL_IN, .COL_OUT, .COL_OE, .CRS_IN, .CRS_OUT, .CRS_OE, .LINK_ACTIVITY_LED_IN,
    .LINK_ACTIVITY_LED_OUT, .LINK_ACTIVITY_LED_OE, .SECOND_STATUS_LED_IN,
    .SECOND_STATUS_LED_OUT, .SECOND_STATUS_LED_OE, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // read before this edge's updates land: the answer stands exactly at the ready edge
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdm
  task automatic send(input logic [4:0] n);
    @(posedge CLK);
    go  <= 1'b1;
    cnt <= n;
    @(posedge CLK);
    go  <= 1'b0;
    do @(posedge CLK); while (busy);
    repeat (4) @(posedge CLK);
  endtask : send
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_strap(input logic [3:0] s);
    logic res;
    res = {1'b0, s[1:0]} != PMLSP_CFG_MII && {1'b0, s[1:0]} != PMLSP_CFG_B2B;
    @(posedge CLK);
    RST        <= 1'b1;
    CHIP_RST_N <= 1'b0;
    strap      <= s;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    chk("oe in reset", 32'h0, COL_OE);
    CHIP_RST_N <= 1'b1;
    repeat (5) @(posedge CLK);
    strap <= ~s;
    rdm("strap stat", PMLSP_STRAP_STAT_ADDR, 32'h1f, {res, s});
    rdm("speed aneg", PMLSP_BASIC_CTRL_ADDR, 32'h3000, {s[3:2], 12'h0});
    rdm("led mode rst", PMLSP_VENDOR_CTRL_ADDR, 32'h30, 32'h0);
    apb(1'b1, PMLSP_STRAP_STAT_ADDR, 32'h0);
    rdm("strap ro", PMLSP_STRAP_STAT_ADDR, 32'h1f, {res, s});
  endtask : t_strap
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      {LINE_CARRIER, LINE_COLLISION} <= i[1:0];
      repeat (3) @(posedge CLK);
      chk("col pin", i[0], COL_OUT);
      chk("crs pin", i[1], CRS_OUT);
      rdm("line stat", PMLSP_LINK_CTRL_ADDR, 32'h6, {i[1:0], 1'b0});
    end
    // a carrier left high would count as activity in the led scenarios
    {LINE_CARRIER, LINE_COLLISION} <= 2'b00;
    repeat (2) @(posedge CLK);
    chk("crs idle", 0, CRS_OUT);
  endtask : t_status
  task automatic t_led(input logic [1:0] mode);
    int n;
    logic last;
    apb(1'b1, PMLSP_VENDOR_CTRL_ADDR, {26'h0, mode, 4'h0});
    rdm("led mode", PMLSP_VENDOR_CTRL_ADDR, 32'h30, {mode, 4'h0});
    LINK_UP <= 1'b0;
    repeat (3) @(posedge CLK);
    if (mode == 2'h0) chk("link_activity_led no link", 1, LINK_ACTIVITY_LED_OUT);
    LINK_UP <= 1'b1;
    repeat (3) @(posedge CLK);
    if (mode == 2'h0) chk("link_activity_led link", 0, LINK_ACTIVITY_LED_OUT);
    else chk("second_status_led idle", 1, SECOND_STATUS_LED_OUT);
    n = 0;
    last = mode[0] ? SECOND_STATUS_LED_OUT : LINK_ACTIVITY_LED_OUT;
    fork
      send(5'd20);
      repeat (24) begin
        @(negedge CLK);
        if ((mode[0] ? SECOND_STATUS_LED_OUT : LINK_ACTIVITY_LED_OUT) !== last) n++;
        last = mode[0] ? SECOND_STATUS_LED_OUT : LINK_ACTIVITY_LED_OUT;
      end
    join
    chk("led blinks", 1, n > 1);
  endtask : t_led
  task automatic t_led_rsv;
    // reserved mode with link up: both leds must stay off, unlike mode 00
    apb(1'b1, PMLSP_VENDOR_CTRL_ADDR, 32'h20);
    repeat (3) @(posedge CLK);
    chk("link_activity_led rsv", 1, LINK_ACTIVITY_LED_OUT);
    chk("second_status_led rsv", 1, SECOND_STATUS_LED_OUT);
  endtask : t_led_rsv
  task automatic t_fifo;
    int k;
    LINE_READY <= 1'b0;
    send(5'd10);
    chk("fifo full", 1, LINE_VALID);
    rdm("drop count", PMLSP_FIFO_STAT_ADDR, 32'hff, 32'h2);
    LINE_READY <= 1'b1;
    k = 0;
    repeat (12) begin
      @(negedge CLK);
      if (LINE_VALID === 1'b1) begin
        chk("nibble", k, LINE_DATA);
        k++;
      end
    end
    chk("nibbles out", 8, k);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped data", PMLSP_SLVERR_DATA, rd);
  endtask : t_fifo
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    t_strap(4'b1001);
    t_strap(4'b0100);
    t_status();
    t_led(2'h0);
    t_led(2'h1);
    t_led_rsv();
    t_fifo();
    results();
  end
endmodule : tb
